// ---- include/pio_pkg.sv ----
// constants for the parallel port block
package pio_pkg;
   // register indices; byte address is four times the index
   localparam logic [4:0] IDX_P1_DIR = 5'h00;
   localparam logic [4:0] IDX_P2_DIR = 5'h01;
   localparam logic [4:0] IDX_P1_DATA = 5'h02;
   localparam logic [4:0] IDX_P2_DATA = 5'h03;
   localparam logic [4:0] IDX_P3_DIR = 5'h04;
   localparam logic [4:0] IDX_P4_DIR = 5'h05;
   localparam logic [4:0] IDX_P3_DATA = 5'h06;
   localparam logic [4:0] IDX_P4_DATA = 5'h07;
   localparam logic [4:0] IDX_P3_CSR = 5'h0f;
   // control/status field positions
   localparam int CSR_FLAG = 7;
   localparam int CSR_IRQ_EN = 6;
   localparam int CSR_OSS = 4;
   localparam int CSR_LATCH = 3;
   // mode strap field in port two data
   localparam int MODE_LSB = 5;
   // port two special lines
   localparam int P2_TIMER_BIT = 1;
   localparam int P2_SCI_TX_BIT = 4;
   // mode codes
   localparam logic [2:0] MODE_SINGLE = 3'h7;
   localparam logic [2:0] MODE_MUX_PART = 3'h6;
   localparam logic [2:0] MODE_NMUX_PART = 3'h5;
   localparam logic [2:0] MODE_SINGLE_TEST = 3'h4;
   // reset values
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // io select decode: upper seven bits zero, bit 8 one
   localparam logic [6:0] IOS_HIGH = 7'h01;
   // external data phase length, clock cycles (covers input sync)
   localparam logic [1:0] DATA_CYCLES = 2'h3;
   // edge count after reset release at which mode pins are caught
   localparam logic [1:0] STRAP_EDGE = 2'h2;
   typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_DESEL, BUS_DATA}
      bus_state_t;
endpackage

// ---- core/sync_two_stage.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_two_stage #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // async in, synced out
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stageOne;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stageOne <= '0;
         syncOut <= '0;
      end else begin
         stageOne <= asyncIn;
         syncOut <= stageOne;
      end
   end
endmodule

// ---- core/parallel_io_ports.sv ----
// four parallel ports with port three handshake and expanded bus
// Functional notes
// - direction bit 1 output, 0 input
// - data and direction registers at fixed offsets
// - reset clears port 1, 2, 4 directions
// - port one always plain eight-bit io
// - mode pins caught into port2 bits 7..5
// - port2 bit1 only input or timer out
// - port two shared with serial and timer
// - expanded modes ignore port3 direction
// - flag and enable request external interrupt
// - latch enable captures port3 on strobe fall
// - strobe select picks write or read pulse
// - strobe falling edge sets read-only flag
// - flag cleared by status then data access
// - read/write high on read, rests high
// - io select decodes 0x0100 to 0x01ff
// - non-mux: port3 data, port4 low address
// - mux: address strobe marks low address phase
// - strobe end gives deselect before data
// - unused port4 address lines stay inputs
// - mux: port4 drives high address bits
// - mode codes select chip and bus modes
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module parallel_io_ports
   import pio_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // axi4-lite write address and data
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // external bus request from the core
   input wire logic extReq,
   input wire logic extWrite,
   input wire logic [15:0] extAddr,
   input wire logic [7:0] extWdata,
   output logic [7:0] extRdata,
   output logic extDone,
   // timer and serial sharing on port two
   input wire logic timerOutEnable,
   input wire logic timerOutLevel,
   input wire logic sciTxEnable,
   input wire logic sciTxLevel,
   // port pins
   input wire logic [7:0] portOneIn,
   output logic [7:0] portOneOut,
   output logic [7:0] portOneOe,
   input wire logic [4:0] portTwoIn,
   output logic [4:0] portTwoOut,
   output logic [4:0] portTwoOe,
   input wire logic [7:0] portThreeIn,
   output logic [7:0] portThreeOut,
   output logic [7:0] portThreeOe,
   input wire logic [7:0] portFourIn,
   output logic [7:0] portFourOut,
   output logic [7:0] portFourOe,
   // strobe control pins
   input wire logic strobeControlOneIn,
   output logic strobeControlOneOut,
   output logic strobeControlOneOe,
   output logic strobeControlTwo,
   output logic externalInterruptLineN
);
   logic [7:0] p1Dir_reg, p1Data_reg, p3Dir_reg, p3Data_reg;
   logic [7:0] p4Dir_reg, p4Data_reg, p3Latch_reg;
   logic [4:0] p2Dir_reg, p2Data_reg;
   logic [2:0] mode_reg;
   logic [1:0] strapCnt_reg;
   logic [7:0] p1Sync, p3Sync, p4Sync;
   logic [4:0] p2Sync, p2ReadDir;
   logic strobeSync, strobePrev_reg, strobeFall;
   logic flag_reg, irqEn_reg, oss_reg, latchEn_reg, latched_reg;
   logic csrArmed_reg, p3WrDone_reg;
   logic [4:0] awIdx_reg, arIdx;
   logic awHave_reg, wHave_reg;
   logic [7:0] wByte_reg;
   logic wLane_reg;
   logic wrFire, rdFire, wrMapped, rdMapped;
   logic p3Access, csrRead;
   logic [7:0] rdValue;
   logic singleChip, nonMux, expanded;
   bus_state_t busState_reg;
   logic [15:0] busAddr_reg;
   logic [7:0] busWdata_reg;
   logic busWrite_reg;
   logic [1:0] dataCnt_reg;
   logic ioSelect;

   // pin synchronisers
   sync_two_stage #(.WIDTH(8)) syncP1 (
      .clk(clk), .rst_n(rst_n), .asyncIn(portOneIn), .syncOut(p1Sync));
   sync_two_stage #(.WIDTH(5)) syncP2 (
      .clk(clk), .rst_n(rst_n), .asyncIn(portTwoIn), .syncOut(p2Sync));
   sync_two_stage #(.WIDTH(8)) syncP3 (
      .clk(clk), .rst_n(rst_n), .asyncIn(portThreeIn),
      .syncOut(p3Sync));
   sync_two_stage #(.WIDTH(8)) syncP4 (
      .clk(clk), .rst_n(rst_n), .asyncIn(portFourIn), .syncOut(p4Sync));
   sync_two_stage #(.WIDTH(1)) syncStrobe (
      .clk(clk), .rst_n(rst_n), .asyncIn(strobeControlOneIn),
      .syncOut(strobeSync));

   assign singleChip = (mode_reg == MODE_SINGLE) ||
                       (mode_reg == MODE_SINGLE_TEST);
   assign nonMux = (mode_reg == MODE_NMUX_PART);
   assign expanded = !singleChip;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strapCnt_reg <= 2'h0;
         mode_reg <= MODE_SINGLE;
      end else if (strapCnt_reg != STRAP_EDGE + 2'h1) begin
         strapCnt_reg <= strapCnt_reg + 2'h1;
         // synced strap pins hold the pin level from here on
         if (strapCnt_reg == STRAP_EDGE) begin
            mode_reg <= p2Sync[2:0];
         end
      end
   end

   // axi write channel acceptance
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awready <= 1'b1;
         wready <= 1'b1;
         awHave_reg <= 1'b0;
         wHave_reg <= 1'b0;
         awIdx_reg <= 5'h00;
         wByte_reg <= 8'h00;
         wLane_reg <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awIdx_reg <= awaddr[6:2];
            awHave_reg <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wByte_reg <= wdata[7:0];
            wLane_reg <= wstrb[0];
            wHave_reg <= 1'b1;
            wready <= 1'b0;
         end
         if (wrFire) begin
            bvalid <= 1'b1;
            bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   assign wrFire = awHave_reg && wHave_reg && !bvalid;
   assign rdFire = arvalid && arready;
   assign arIdx = araddr[6:2];

   always_comb begin
      if (awIdx_reg <= IDX_P4_DATA) begin
         wrMapped = 1'b1;
      end else if (awIdx_reg == IDX_P3_CSR) begin
         wrMapped = 1'b1;
      end else begin
         wrMapped = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         p1Dir_reg <= DIR_RESET;
         p2Dir_reg <= DIR_RESET[4:0];
         p3Dir_reg <= DIR_RESET;
         p4Dir_reg <= DIR_RESET;
         p1Data_reg <= DATA_RESET;
         p2Data_reg <= DATA_RESET[4:0];
         p3Data_reg <= DATA_RESET;
         p4Data_reg <= DATA_RESET;
      end else if (wrFire && wLane_reg) begin
         if (awIdx_reg == IDX_P1_DIR) begin
            p1Dir_reg <= wByte_reg;
         end else if (awIdx_reg == IDX_P2_DIR) begin
            p2Dir_reg <= wByte_reg[4:0];
         end else if (awIdx_reg == IDX_P1_DATA) begin
            p1Data_reg <= wByte_reg;
         end else if (awIdx_reg == IDX_P2_DATA) begin
            // mode bits stay read-only
            p2Data_reg <= wByte_reg[4:0];
         end else if (awIdx_reg == IDX_P3_DIR) begin
            p3Dir_reg <= wByte_reg;
         end else if (awIdx_reg == IDX_P4_DIR) begin
            p4Dir_reg <= wByte_reg;
         end else if (awIdx_reg == IDX_P3_DATA) begin
            p3Data_reg <= wByte_reg;
         end else if (awIdx_reg == IDX_P4_DATA) begin
            p4Data_reg <= wByte_reg;
         end
      end
   end

   // handshake control bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqEn_reg <= 1'b0;
         oss_reg <= 1'b0;
         latchEn_reg <= 1'b0;
      end else if (wrFire && wLane_reg && awIdx_reg == IDX_P3_CSR) begin
         irqEn_reg <= wByte_reg[CSR_IRQ_EN];
         oss_reg <= wByte_reg[CSR_OSS];
         latchEn_reg <= wByte_reg[CSR_LATCH];
      end
   end

   // strobe falling edge from synced samples
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strobePrev_reg <= 1'b0; // synced reset zero is no edge
      end else begin
         strobePrev_reg <= strobeSync;
      end
   end
   assign strobeFall = strobePrev_reg && !strobeSync && singleChip;

   assign p3Access = (wrFire && awIdx_reg == IDX_P3_DATA) ||
                     (rdFire && arIdx == IDX_P3_DATA);
   assign csrRead = rdFire && arIdx == IDX_P3_CSR;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_reg <= 1'b0;
         csrArmed_reg <= 1'b0;
      end else begin
         if (csrRead) begin
            csrArmed_reg <= 1'b1;
         end else if (p3Access) begin
            csrArmed_reg <= 1'b0;
         end
         if (strobeFall) begin
            flag_reg <= 1'b1;
         end else if (p3Access && csrArmed_reg) begin
            flag_reg <= 1'b0;
         end
      end
   end

   // input latch, reopened by port3 read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latched_reg <= 1'b0;
         p3Latch_reg <= 8'h00;
      end else if (strobeFall && latchEn_reg && !latched_reg) begin
         latched_reg <= 1'b1;
         p3Latch_reg <= p3Sync;
      end else if (rdFire && arIdx == IDX_P3_DATA) begin
         latched_reg <= 1'b0;
      end
   end

   // timer line always reads back as an input
   always_comb begin
      p2ReadDir = p2Dir_reg;
      p2ReadDir[P2_TIMER_BIT] = 1'b0;
   end

   // read mux; direction registers read zero
   always_comb begin
      rdValue = 8'h00;
      rdMapped = 1'b1;
      if (arIdx == IDX_P1_DIR || arIdx == IDX_P2_DIR) begin
         rdValue = 8'h00;
      end else if (arIdx == IDX_P3_DIR || arIdx == IDX_P4_DIR) begin
         rdValue = 8'h00;
      end else if (arIdx == IDX_P1_DATA) begin
         rdValue = (p1Data_reg & p1Dir_reg) | (p1Sync & ~p1Dir_reg);
      end else if (arIdx == IDX_P2_DATA) begin
         rdValue = {mode_reg,
                    (p2Data_reg & p2ReadDir) | (p2Sync & ~p2ReadDir)};
      end else if (arIdx == IDX_P3_DATA) begin
         if (latched_reg) begin
            rdValue = (p3Data_reg & p3Dir_reg) | (p3Latch_reg & ~p3Dir_reg);
         end else begin
            rdValue = (p3Data_reg & p3Dir_reg) | (p3Sync & ~p3Dir_reg);
         end
      end else if (arIdx == IDX_P4_DATA) begin
         rdValue = (p4Data_reg & p4Dir_reg) | (p4Sync & ~p4Dir_reg);
      end else if (arIdx == IDX_P3_CSR) begin
         rdValue[CSR_FLAG] = flag_reg;
         rdValue[CSR_IRQ_EN] = irqEn_reg;
         rdValue[CSR_OSS] = oss_reg;
         rdValue[CSR_LATCH] = latchEn_reg;
      end else begin
         rdMapped = 1'b0;
      end
   end

   // axi read channel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (rdFire) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, rdValue};
         rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
      end
   end

   // external bus sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busState_reg <= BUS_IDLE;
         busAddr_reg <= 16'h0000;
         busWdata_reg <= 8'h00;
         busWrite_reg <= 1'b0;
         dataCnt_reg <= 2'h0;
         extRdata <= 8'h00;
         extDone <= 1'b0;
      end else begin
         extDone <= 1'b0;
         case (busState_reg)
            BUS_IDLE: begin
               if (extReq && expanded && !extDone) begin
                  busAddr_reg <= extAddr;
                  busWdata_reg <= extWdata;
                  busWrite_reg <= extWrite;
                  dataCnt_reg <= 2'h0;
                  busState_reg <= nonMux ? BUS_DATA : BUS_ADDR;
               end
            end
            BUS_ADDR: begin
               busState_reg <= BUS_DESEL;
            end
            BUS_DESEL: begin
               busState_reg <= BUS_DATA;
            end
            BUS_DATA: begin
               dataCnt_reg <= dataCnt_reg + 2'h1;
               if (dataCnt_reg == DATA_CYCLES - 2'h1) begin
                  extRdata <= p3Sync;
                  extDone <= 1'b1;
                  busState_reg <= BUS_IDLE;
               end
            end
            default: busState_reg <= BUS_IDLE;
         endcase
      end
   end

   assign ioSelect = busAddr_reg[15:9] == IOS_HIGH[6:0] >> 1 &&
                     busAddr_reg[8];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         portOneOut <= 8'h00;
         portOneOe <= 8'h00;
      end else begin
         portOneOut <= p1Data_reg;
         portOneOe <= p1Dir_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         portTwoOut <= 5'h00;
         portTwoOe <= 5'h00;
      end else begin
         portTwoOut <= p2Data_reg;
         portTwoOe <= p2Dir_reg;
         portTwoOut[P2_TIMER_BIT] <= timerOutLevel;
         portTwoOe[P2_TIMER_BIT] <= timerOutEnable;
         if (sciTxEnable) begin
            portTwoOut[P2_SCI_TX_BIT] <= sciTxLevel;
            portTwoOe[P2_SCI_TX_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         portThreeOut <= 8'h00;
         portThreeOe <= 8'h00;
      end else if (singleChip) begin
         portThreeOut <= p3Data_reg;
         portThreeOe <= p3Dir_reg;
      end else if (busState_reg == BUS_ADDR ||
                   (busState_reg == BUS_IDLE && extReq && !extDone &&
                    !nonMux)) begin
         portThreeOut <= (busState_reg == BUS_IDLE) ?
                         extAddr[7:0] : busAddr_reg[7:0];
         portThreeOe <= 8'hff;
      end else if (busState_reg == BUS_DATA && busWrite_reg) begin
         portThreeOut <= busWdata_reg;
         portThreeOe <= 8'hff;
      end else begin
         portThreeOut <= 8'h00;
         portThreeOe <= 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         portFourOut <= 8'h00;
         portFourOe <= 8'h00;
      end else if (singleChip) begin
         portFourOut <= p4Data_reg;
         portFourOe <= p4Dir_reg;
      end else if (nonMux) begin
         portFourOut <= busAddr_reg[7:0] & p4Dir_reg;
         portFourOe <= p4Dir_reg;
      end else begin
         portFourOut <= busAddr_reg[15:8] & p4Dir_reg;
         portFourOe <= p4Dir_reg;
      end
   end

   // write strobe waits for new data on the pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         p3WrDone_reg <= 1'b0;
      end else begin
         p3WrDone_reg <= wrFire && awIdx_reg == IDX_P3_DATA;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strobeControlOneOut <= 1'b0;
         strobeControlOneOe <= 1'b0;
         strobeControlTwo <= 1'b1;
      end else if (singleChip) begin
         strobeControlOneOut <= 1'b0;
         strobeControlOneOe <= 1'b0;
         strobeControlTwo <= !(oss_reg ?
            p3WrDone_reg :
            (rdFire && arIdx == IDX_P3_DATA));
      end else begin
         strobeControlOneOe <= 1'b1;
         strobeControlOneOut <= nonMux ?
            !(busState_reg == BUS_DATA && ioSelect) :
            (busState_reg == BUS_ADDR);
         strobeControlTwo <= !(busState_reg == BUS_DATA && busWrite_reg);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         externalInterruptLineN <= 1'b1;
      end else begin
         externalInterruptLineN <= !(flag_reg && irqEn_reg);
      end
   end

   // checks
   a_irq_follows_flag: assert property (@(posedge clk) disable iff (!rst_n)
      flag_reg && irqEn_reg |=> !externalInterruptLineN)
      else $error("interrupt not raised");
   a_flag_on_fall: assert property (@(posedge clk) disable iff (!rst_n)
      strobeFall |=> flag_reg)
      else $error("flag not set on strobe fall");
   a_flag_clear_cause: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(flag_reg) |-> $past(p3Access) && $past(csrArmed_reg))
      else $error("flag cleared without sequence");
   a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
      latched_reg && !rdFire |=> $stable(p3Latch_reg))
      else $error("latched data changed");
   a_rw_rest_high: assert property (@(posedge clk) disable iff (!rst_n)
      expanded && busState_reg == BUS_IDLE |=> strobeControlTwo)
      else $error("read/write not resting high");
   a_strobe_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      singleChip && oss_reg && wrFire && awIdx_reg == IDX_P3_DATA
      |=> ##1 !strobeControlTwo ##1 strobeControlTwo)
      else $error("output strobe not one cycle");
   a_desel_gap: assert property (@(posedge clk) disable iff (!rst_n)
      expanded && busState_reg == BUS_DESEL |=> portThreeOe == 8'h00)
      else $error("bus driven during deselect");
   a_addr_strobe: assert property (@(posedge clk) disable iff (!rst_n)
      !singleChip && !nonMux && busState_reg == BUS_ADDR
      |=> strobeControlOneOut && portThreeOut == busAddr_reg[7:0])
      else $error("address strobe phase wrong");
   a_p4_inputs: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> portFourOe == $past(p4Dir_reg))
      else $error("port four enable not from direction");
   c_strobe_fall: cover property (@(posedge clk) disable iff (!rst_n)
      strobeFall && latchEn_reg);
   c_ext_done: cover property (@(posedge clk) disable iff (!rst_n)
      extDone);
   c_flag_clear: cover property (@(posedge clk) disable iff (!rst_n)
      $fell(flag_reg));
endmodule

// ---- bench/port_three_peer.sv ----
// far-side peripheral on the port three handshake pins
`timescale 1ns/1ps
module port_three_peer (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // device side of the pins
   input wire logic [7:0] pinOut,
   input wire logic [7:0] pinOe,
   input wire logic strobeOutN,
   output logic [7:0] pinLevel,
   output logic strobeInN,
   // bench commands and observations
   input wire logic [7:0] sendData,
   input wire logic sendStrobe,
   output logic [7:0] seenData,
   output logic [7:0] seenCount
);
   // wire level: device where enabled, peer elsewhere
   assign pinLevel = (pinOut & pinOe) | (sendData & ~pinOe);
   assign strobeInN = ~sendStrobe;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seenData <= 8'h00;
         seenCount <= 8'h00;
      end else if (!strobeOutN) begin
         seenData <= pinLevel;
         seenCount <= seenCount + 8'h01;
      end
   end
endmodule

// ---- bench/parallel_io_ports_tb_top.sv ----
// register-level bench for the parallel port block
`timescale 1ns/1ps
module parallel_io_ports_tb_top;
   import pio_pkg::*;
   logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, extReq, extWrite, extDone;
   logic [31:0] awaddr, wdata, araddr, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, lastResp;
   logic [15:0] extAddr;
   logic [7:0] extWdata, extRdata, p1Out, p1Oe, p1In, p1Ext, p3Out, p3Oe;
   logic [7:0] p3In, p4Out, p4Oe, p4Ext, sendData, seenData, seenCount;
   logic [7:0] base;
   logic [4:0] p2Out, p2Oe, p2In, p2Ext;
   logic tmrEn, tmrLvl, sciEn, sciLvl, sc1In, sc1Out, sc1Oe, sc2, irqN;
   logic sendStrobe;
   int miscompares, checked;
   // pin levels seen by the device
   assign p1In = (p1Out & p1Oe) | (p1Ext & ~p1Oe);
   assign p2In = (p2Out & p2Oe) | (p2Ext & ~p2Oe);
   parallel_io_ports i_parallel_io_ports (.clk, .rst_n, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .extReq, .extWrite, .extAddr, .extWdata, .extRdata, .extDone,
      .timerOutEnable(tmrEn), .timerOutLevel(tmrLvl),
      .sciTxEnable(sciEn), .sciTxLevel(sciLvl), .portOneIn(p1In),
      .portOneOut(p1Out), .portOneOe(p1Oe), .portTwoIn(p2In),
      .portTwoOut(p2Out), .portTwoOe(p2Oe), .portThreeIn(p3In),
      .portThreeOut(p3Out), .portThreeOe(p3Oe), .portFourIn(p4Ext),
      .portFourOut(p4Out), .portFourOe(p4Oe), .strobeControlOneIn(sc1In),
      .strobeControlOneOut(sc1Out), .strobeControlOneOe(sc1Oe),
      .strobeControlTwo(sc2), .externalInterruptLineN(irqN));
   port_three_peer i_port_three_peer (.clk, .rst_n, .pinOut(p3Out),
      .pinOe(p3Oe), .strobeOutN(sc2), .pinLevel(p3In), .strobeInN(sc1In),
      .sendData, .sendStrobe, .seenData, .seenCount);
   // clock
   always #5 clk = ~clk;
   // verdict and end of run
   task automatic wrap_up;
      $display("counts: checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // hang guard for bus waits
   task automatic stuck(input int n);
      if (n >= 50) begin
         miscompares++;
         $display("unexpected at %0t: no bus answer", $time);
         wrap_up();
      end
   endtask
   task automatic wr(input logic [4:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= {25'h0, idx, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 50);
      bready <= 1'b0;
      lastResp = bresp;
      stuck(n);
   endtask
   task automatic rd(input logic [4:0] idx, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= {25'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 50);
      rready <= 1'b0;
      d = rdata;
      lastResp = rresp;
      stuck(n);
   endtask
   // input strobe low for three cycles, then settle
   task automatic pulse_in;
      sendStrobe <= 1'b1;
      repeat (3) @(posedge clk);
      sendStrobe <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   // one external bus read, request dropped on done
   task automatic ext(input logic [15:0] a);
      int n;
      n = 0;
      @(posedge clk);
      extAddr <= a;
      extReq <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (!extDone && n < 50);
      extReq <= 1'b0;
      stuck(n);
   endtask
   // main sequence
   initial begin
      {clk, rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
      {extReq, extWrite, extAddr, extWdata, awaddr, araddr, wdata} = '0;
      {tmrEn, tmrLvl, sciEn, sciLvl, sendStrobe, sendData} = '0;
      {miscompares, checked} = '0;
      wstrb = 4'hf;
      p1Ext = 8'h5a;
      p2Ext = 5'h07;
      p4Ext = 8'h33;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk({p1Oe, p4Oe, 3'h0, p2Oe, 6'h0, sc2, irqN}, 32'h3);
      rd(IDX_P2_DATA, v);
      chk(v, 32'he7);
      $display("test reset done");
      wr(IDX_P1_DIR, 8'hf0);
      wr(IDX_P1_DATA, 8'ha5);
      wr(IDX_P4_DIR, 8'h0f);
      wr(IDX_P2_DIR, 8'h1f);
      wr(IDX_P2_DATA, 8'h00);
      repeat (2) @(posedge clk);
      chk({p1Oe, p1Out & p1Oe, p4Oe, 3'h0, p2Oe}, 32'hf0a00f1d);
      rd(IDX_P1_DATA, v);
      chk(v, 32'haa);
      rd(IDX_P2_DATA, v);
      chk(v, 32'he2);
      {tmrEn, tmrLvl, sciEn, sciLvl} <= 4'hf;
      repeat (3) @(posedge clk);
      chk({22'h0, p2Oe, p2Out}, {22'h0, 5'h1f, 5'h12});
      $display("test ports done");
      for (int i = 0; i < 16; i++) begin
         rd(i[4:0], v);
         chk({30'h0, lastResp}, (i < 8 || i == 15) ? 32'h0 : 32'h2);
      end
      wr(5'h09, 8'hff);
      chk({30'h0, lastResp}, {30'h0, RESP_SLVERR});
      $display("test map done");
      wr(IDX_P3_CSR, 8'h48);
      sendData <= 8'h3c;
      pulse_in();
      chk({31'h0, irqN}, 32'h0);
      base = seenCount;
      sendData <= 8'hc3;
      rd(IDX_P3_DATA, v);
      chk(v, 32'h3c);
      repeat (2) @(posedge clk);
      chk({23'h0, seenCount - base, irqN}, 32'h3);
      wr(IDX_P3_CSR, 8'h08);
      chk({31'h0, irqN}, 32'h1);
      wr(IDX_P3_DIR, 8'hff);
      wr(IDX_P3_CSR, 8'h58);
      pulse_in();
      rd(IDX_P3_CSR, v);
      chk(v & 32'hd8, 32'hd8);
      wr(IDX_P3_DATA, 8'h96);
      repeat (3) @(posedge clk);
      chk({7'h0, p3Oe, seenCount - base, seenData, irqN},
         {7'h0, 8'hff, 8'h02, 8'h96, 1'b1});
      $display("test handshake done");
      rst_n <= 1'b0;
      p2Ext <= 5'h06;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      wr(IDX_P4_DIR, 8'h0f);
      ext(16'h12c4);
      chk({6'h0, sc2, sc1Oe, p4Oe, extRdata, p4Out},
         {6'h0, 2'h3, 8'h0f, 8'hc3, 8'h02});
      $display("test expanded done");
      wrap_up();
   end
endmodule
